// [slpc_map.svh]
// register offsets and reset values of the link parameter bank
`ifndef SLPC_MAP_SVH
`define SLPC_MAP_SVH
`define SLPC_ADDR_W            12
`define SLPC_OFS_OCTETS        12'h454
`define SLPC_OFS_MFLEN         12'h455
`define SLPC_OFS_CONV          12'h456
`define SLPC_OFS_CTLRES        12'h457
`define SLPC_OFS_CLSBITS       12'h458
`define SLPC_OFS_VERSAMP       12'h459
`define SLPC_RST_OCTETS        8'h00
`define SLPC_RST_MFLEN         5'h1f
`define SLPC_RST_CONV          8'h01
`define SLPC_RST_CTLBITS       2'h0
`define SLPC_RST_RES           5'h0f
`define SLPC_RST_CLASS         3'h1
`define SLPC_RST_SAMPW         5'h0f
`define SLPC_RST_VER           3'h1
`define SLPC_RST_SAMP          5'h00
`define SLPC_MFLEN_16          5'h0f
`define SLPC_MFLEN_32          5'h1f
`define SLPC_LANES_EIGHT       5'h07
`define SLPC_CONV_FOUR         8'h03
`endif

// [slpc_pkg.sv]
// types of the serial link parameter bank
package slpc_pkg;
   typedef struct packed {
      logic [7:0] octets_m1;
      logic [4:0] mf_len_m1;
      logic [7:0] conv_m1;
      logic [1:0] ctl_bits;
      logic [4:0] res_m1;
      logic [2:0] link_timing_class;
      logic [4:0] sample_width_minus_one;
      logic [2:0] link_standard_version;
      logic [4:0] samples_m1;
   } slpc_cfg_t;
endpackage : slpc_pkg

// [slpc_regs.sv]
// serial link parameter configuration registers
//
// Overview of operation
// - octets per frame minus one; 0,1,3 valid
// - frames per multiframe 16 or 32, resets 32
// - eight lanes allowed only in single link
// - converters minus one; four single link only
// - samples per frame minus one, 0 or 1
// - lanes minus one; 0,1,3,7 lanes encoding
`timescale 1ns/1ps
`include "slpc_map.svh"

module slpc_regs
   import slpc_pkg::*;
(
   input  wire logic                    i_clk,         // device clock
   input  wire logic                    i_rst,         // async reset, high
   input  wire logic [`SLPC_ADDR_W-1:0] i_addr,        // register address
   input  wire logic                    i_wr,          // write strobe
   input  wire logic [7:0]              i_wdata,       // write data
   input  wire logic                    i_dual_link,   // dual link mode level
   input  wire logic [4:0]              i_lanes_m1,    // lanes per converter minus one
   output logic      [7:0]              o_rdata,       // registered read data
   output slpc_cfg_t                    o_cfg,         // registered parameters, zero in reset
   output logic                         o_cfg_bad      // unsupported combination
);
   // ==========================================
   // helpers
   // lane and octet counts share the one/two/four encoding of a count minus one
   // one function keeps both decodes in step if the encoding ever grows
   function automatic logic is_one_two_four(input logic [7:0] count_m1);
      return (count_m1 == 8'h00) || (count_m1 == 8'h01) || (count_m1 == 8'h03);
   endfunction : is_one_two_four

   // ==========================================
   // decode
   slpc_cfg_t cfg;
   wire       wr_oct  = i_wr && (i_addr == `SLPC_OFS_OCTETS);
   wire       wr_mf   = i_wr && (i_addr == `SLPC_OFS_MFLEN);
   wire       wr_conv = i_wr && (i_addr == `SLPC_OFS_CONV);
   wire       wr_cr   = i_wr && (i_addr == `SLPC_OFS_CTLRES);
   wire       wr_cls  = i_wr && (i_addr == `SLPC_OFS_CLSBITS);
   wire       wr_vs   = i_wr && (i_addr == `SLPC_OFS_VERSAMP);
   logic [7:0] next_rdata;

   // reserved bits are zero-filled, fields echo the stored value
   always_comb begin
      case (i_addr)
         `SLPC_OFS_OCTETS:  next_rdata = cfg.octets_m1;
         `SLPC_OFS_MFLEN:   next_rdata = {3'h0, cfg.mf_len_m1};
         `SLPC_OFS_CONV:    next_rdata = cfg.conv_m1;
         `SLPC_OFS_CTLRES:  next_rdata = {cfg.ctl_bits, 1'b0, cfg.res_m1};
         `SLPC_OFS_CLSBITS: next_rdata = {cfg.link_timing_class, cfg.sample_width_minus_one};
         `SLPC_OFS_VERSAMP: next_rdata = {cfg.link_standard_version, cfg.samples_m1};
         default:           next_rdata = 8'h00;
      endcase
   end

   // ==========================================
   // combination checks
   // lanes and dual link come from the neighbouring lane register; checked here, not stored
   wire bad_lanes = i_dual_link && (i_lanes_m1 == `SLPC_LANES_EIGHT);
   wire bad_conv  = i_dual_link && (cfg.conv_m1 == `SLPC_CONV_FOUR);
   wire lane_ok   = is_one_two_four({3'h0, i_lanes_m1}) || (i_lanes_m1 == `SLPC_LANES_EIGHT);
   wire oct_ok    = is_one_two_four(cfg.octets_m1);
   wire mf_ok     = (cfg.mf_len_m1 == `SLPC_MFLEN_16) || (cfg.mf_len_m1 == `SLPC_MFLEN_32);
   wire mf_f1_ok  = (cfg.octets_m1 != 8'h00) || (cfg.mf_len_m1 == `SLPC_MFLEN_32);
   wire fixed_ok  = (cfg.ctl_bits == 2'h0) && (cfg.res_m1 == `SLPC_RST_RES)
                    && (cfg.sample_width_minus_one == `SLPC_RST_SAMPW);
   wire samp_ok   = cfg.samples_m1 <= 5'h01;
   wire next_bad  = bad_lanes || bad_conv || !lane_ok || !oct_ok || !mf_ok || !mf_f1_ok
                    || !fixed_ok || !samp_ok;

   // ==========================================
   // storage
   // unsupported values are kept as written; only the flag reports them
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg.octets_m1              <= `SLPC_RST_OCTETS;
         cfg.mf_len_m1              <= `SLPC_RST_MFLEN;
         cfg.conv_m1                <= `SLPC_RST_CONV;
         cfg.ctl_bits               <= `SLPC_RST_CTLBITS;
         cfg.res_m1                 <= `SLPC_RST_RES;
         cfg.link_timing_class      <= `SLPC_RST_CLASS;
         cfg.sample_width_minus_one <= `SLPC_RST_SAMPW;
         cfg.link_standard_version  <= `SLPC_RST_VER;
         cfg.samples_m1             <= `SLPC_RST_SAMP;
      end else begin
         if (wr_oct) cfg.octets_m1 <= i_wdata;
         if (wr_mf) cfg.mf_len_m1 <= i_wdata[4:0];
         if (wr_conv) cfg.conv_m1 <= i_wdata;
         if (wr_cr) begin
            cfg.ctl_bits <= i_wdata[7:6];
            cfg.res_m1   <= i_wdata[4:0];
         end
         if (wr_cls) begin
            cfg.link_timing_class      <= i_wdata[7:5];
            cfg.sample_width_minus_one <= i_wdata[4:0];
         end
         if (wr_vs) begin
            cfg.link_standard_version <= i_wdata[7:5];
            cfg.samples_m1            <= i_wdata[4:0];
         end
      end
   end

   // outputs lag storage by one edge so every port leaves a flop
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata   <= 8'h00;
         o_cfg     <= '0;
         o_cfg_bad <= 1'b0;
      end else begin
         o_rdata   <= next_rdata;
         o_cfg     <= cfg;
         o_cfg_bad <= next_bad;
      end
   end

   // ==========================================
   // checks
   property p_mf_reset;
      @(posedge i_clk) $rose(!i_rst) |-> cfg.mf_len_m1 == `SLPC_MFLEN_32;
   endproperty
   a_mf_reset: assert property (p_mf_reset) else $error("multiframe reset wrong");

   property p_readback;
      @(posedge i_clk) disable iff (i_rst)
      wr_oct ##1 (i_addr == `SLPC_OFS_OCTETS && !i_wr) |=> o_rdata == $past(i_wdata, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("octets readback wrong");

   property p_rsvd_zero;
      @(posedge i_clk) disable iff (i_rst)
      i_addr == `SLPC_OFS_MFLEN |=> o_rdata[7:5] == 3'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

   property p_ctlres_rsvd;
      @(posedge i_clk) disable iff (i_rst)
      i_addr == `SLPC_OFS_CTLRES |=> o_rdata[5] == 1'b0;
   endproperty
   a_ctlres_rsvd: assert property (p_ctlres_rsvd) else $error("bit five not zero");

   // sampled reset term skips the release edge, where the flag is still cleared
   property p_eight_dual;
      @(posedge i_clk) disable iff (i_rst)
      (!i_rst && i_dual_link && i_lanes_m1 == `SLPC_LANES_EIGHT) |=> o_cfg_bad;
   endproperty
   a_eight_dual: assert property (p_eight_dual) else $error("eight lanes in dual link accepted");

   property p_four_dual;
      @(posedge i_clk) disable iff (i_rst)
      (i_dual_link && cfg.conv_m1 == `SLPC_CONV_FOUR) |=> o_cfg_bad;
   endproperty
   a_four_dual: assert property (p_four_dual) else $error("four converters in dual link accepted");

   property p_bad_lanes;
      @(posedge i_clk) disable iff (i_rst)
      (!i_rst && i_lanes_m1 == 5'h02) |=> o_cfg_bad;
   endproperty
   a_bad_lanes: assert property (p_bad_lanes) else $error("three lanes accepted");

   property p_res_hold;
      @(posedge i_clk) disable iff (i_rst)
      !wr_cr |=> $stable(cfg.res_m1);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("resolution changed without write");

   property p_samp_bad;
      @(posedge i_clk) disable iff (i_rst)
      (cfg.samples_m1 > 5'h01) |=> o_cfg_bad;
   endproperty
   a_samp_bad: assert property (p_samp_bad) else $error("bad sample count accepted");

   property p_oct_bad;
      @(posedge i_clk) disable iff (i_rst)
      !(cfg.octets_m1 inside {8'h00, 8'h01, 8'h03}) |=> o_cfg_bad;
   endproperty
   a_oct_bad: assert property (p_oct_bad) else $error("bad octet count accepted");

   property p_mf_bad;
      @(posedge i_clk) disable iff (i_rst)
      !(cfg.mf_len_m1 inside {`SLPC_MFLEN_16, `SLPC_MFLEN_32}) |=> o_cfg_bad;
   endproperty
   a_mf_bad: assert property (p_mf_bad) else $error("bad multiframe length accepted");

   property p_f1_mf;
      @(posedge i_clk) disable iff (i_rst)
      (cfg.octets_m1 == 8'h00 && cfg.mf_len_m1 != `SLPC_MFLEN_32) |=> o_cfg_bad;
   endproperty
   a_f1_mf: assert property (p_f1_mf) else $error("short multiframe with one octet accepted");

   property p_ctl_bad;
      @(posedge i_clk) disable iff (i_rst)
      (cfg.ctl_bits != 2'h0) |=> o_cfg_bad;
   endproperty
   a_ctl_bad: assert property (p_ctl_bad) else $error("control bits accepted");

   property p_res_bad;
      @(posedge i_clk) disable iff (i_rst)
      (cfg.res_m1 != `SLPC_RST_RES || cfg.sample_width_minus_one != `SLPC_RST_SAMPW) |=> o_cfg_bad;
   endproperty
   a_res_bad: assert property (p_res_bad) else $error("bad sample width accepted");

   property p_cfg_copy;
      @(posedge i_clk) disable iff (i_rst)
      !i_rst |=> o_cfg == $past(cfg);
   endproperty
   a_cfg_copy: assert property (p_cfg_copy) else $error("parameter copy lags wrongly");

   property p_unmapped_zero;
      @(posedge i_clk) disable iff (i_rst)
      (i_addr < `SLPC_OFS_OCTETS || i_addr > `SLPC_OFS_VERSAMP) |=> o_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
endmodule : slpc_regs

// [slpc_tx_model.sv]
// far-side transmitter model: framing it is able to send
`timescale 1ns/1ps

module slpc_tx_model
   import slpc_pkg::*;
(
   input  wire slpc_cfg_t i_cfg,    // parameters the receiver expects
   output logic           o_agree,             // framing matches what we send
   output logic           o_high_density_flag  // density flag the transmitter sends
);
   // ==========================================
   // framing the transmitter packs
   assign o_agree = (i_cfg.octets_m1 inside {8'h00, 8'h01, 8'h03})
                  && (i_cfg.mf_len_m1 inside {5'h0f, 5'h1f})
                  && (i_cfg.octets_m1 != 8'h00 || i_cfg.mf_len_m1 == 5'h1f)
                  && i_cfg.ctl_bits == 2'h0 && i_cfg.res_m1 == 5'h0f
                  && i_cfg.sample_width_minus_one == 5'h0f
                  && i_cfg.samples_m1 <= 5'h01;
   assign o_high_density_flag = (i_cfg.octets_m1 == 8'h00);
endmodule : slpc_tx_model

// [tb_serial_link_param_config.sv]
// self-checking bench of the link parameter bank
`timescale 1ns/1ps

module tb_serial_link_param_config
   import slpc_pkg::*;
;
   // ==========================================
   // signals and reference model
   logic       i_clk = 0, i_rst = 1, i_wr = 0, i_dual_link = 0, o_cfg_bad, agree, hd;
   logic [11:0] i_addr = 12'h000;
   logic [7:0] i_wdata = 8'h00, o_rdata;
   logic [4:0] i_lanes_m1 = 5'h00;
   slpc_cfg_t  o_cfg;
   int         num_errors = 0, checked = 0, cyc = 0, k;
   logic [7:0] m [6] = '{8'h00, 8'h1f, 8'h01, 8'h0f, 8'h2f, 8'h20};
   logic [7:0] m_rst [6] = '{8'h00, 8'h1f, 8'h01, 8'h0f, 8'h2f, 8'h20};
   logic [7:0] msk [6] = '{8'hff, 8'h1f, 8'hff, 8'hdf, 8'hff, 8'hff};
   logic [7:0] good [6][2] = '{'{8'h00, 8'h03}, '{8'h1f, 8'h0f}, '{8'h01, 8'h03},
                               '{8'h0f, 8'h0f}, '{8'h2f, 8'h0f}, '{8'h20, 8'h21}};
   logic [4:0] lanes [5] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h02};
   always #5 i_clk = ~i_clk;
   slpc_regs dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
      .i_dual_link(i_dual_link), .i_lanes_m1(i_lanes_m1), .o_rdata(o_rdata), .o_cfg(o_cfg), .o_cfg_bad(o_cfg_bad));
   slpc_tx_model tx_u (.i_cfg(o_cfg), .o_agree(agree), .o_high_density_flag(hd));
   task chk(input logic [43:0] seen, input logic [43:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic bad();
      int oc = m[0], mf = m[1], cv = m[2], ln = i_lanes_m1;
      return !(oc inside {0, 1, 3}) || !(mf inside {15, 31}) || (oc == 0 && mf != 31)
         || m[3] != 8'h0f || m[4][4:0] != 5'h0f || m[5][4:0] > 1 || !(ln inside {0, 1, 3, 7})
         || (i_dual_link && (ln == 7 || cv == 3));
   endfunction : bad
   // ==========================================
   // register port tasks
   task wr(input int i, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= 12'h454 + 12'(i);
      i_wr <= 1'b1;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      m[i] = d & msk[i];
   endtask : wr
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_addr <= a;
      @(posedge i_clk);
      #1 chk(o_rdata, e);
   endtask : rd
   task check_all();
      for (int i = 0; i < 6; i++) rd(12'h454 + 12'(i), m[i]);
      chk(o_cfg, {m[0], m[1][4:0], m[2], m[3][7:6], m[3][4:0], m[4], m[5]});
      chk(o_cfg_bad, bad());
      if (o_cfg_bad === 1'b0) chk(agree, 1'b1);
      chk(hd, m[0] == 8'h00);
   endtask : check_all
   // ==========================================
   // run control
   task conclude();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'h6d163de9));
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      check_all();
      rd(12'h45a, 8'h00);
      $display("reset test done");
      // half the writes are legal values so good and bad settings both occur
      for (int t = 0; t < 80; t++) begin
         k = $urandom % 6;
         wr(k, ($urandom % 2) ? 8'($urandom) : good[k][$urandom % 2]);
         i_lanes_m1 <= lanes[$urandom % 5];
         i_dual_link <= 1'($urandom);
         check_all();
      end
      $display("random test done");
      // a second reset in mid-run must bring back every reset value
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      m = m_rst;
      check_all();
      $display("mid-run reset test done");
      conclude();
   end
endmodule : tb_serial_link_param_config
